// *** pkg/fbi_pkg.sv ***
// Constants for the FIFO, bulk, drive port and debug event status block
package fbi_pkg;
  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] FIFO_EVT_IDX = 8'h04;
  localparam logic [7:0] BULK_EVT_IDX = 8'h05;
  localparam logic [7:0] DRV_EVT_IDX = 8'h06;
  localparam logic [7:0] DBG_EVT_IDX = 8'h07;
  localparam logic [7:0] CTRL_IDX = 8'h20;
  localparam logic [9:0] FIFO_EVT_ADR = {FIFO_EVT_IDX, 2'b00};
  localparam logic [9:0] BULK_EVT_ADR = {BULK_EVT_IDX, 2'b00};
  localparam logic [9:0] DRV_EVT_ADR = {DRV_EVT_IDX, 2'b00};
  localparam logic [9:0] DBG_EVT_ADR = {DBG_EVT_IDX, 2'b00};
  localparam logic [9:0] CTRL_ADR = {CTRL_IDX, 2'b00};
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] EVT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FE_DESC = 7;
  localparam int FE_RAM = 6;
  localparam int FE_DRV = 5;
  localparam int FE_DMA1 = 4;
  localparam int FE_FULL = 3;
  localparam int FE_EMPTY = 2;
  localparam int FE_DMA0 = 0;
  localparam int BE_CBW_DONE = 7;
  localparam int BE_CBW_LEN = 6;
  localparam int BE_COMMAND_WRAPPER_ERROR = 5;
  localparam int BE_CSW_DONE = 3;
  localparam int BE_STATUS_WRAPPER_ERROR = 2;
  localparam int DE_REG_DONE = 7;
  localparam int DE_REG_ERR = 6;
  localparam int DE_SEQ_DONE = 5;
  localparam int DE_AUTO_DONE = 4;
  localparam int DE_DMA_DONE = 2;
  localparam int DE_IRQ = 1;
  localparam int DE_TERM = 0;
  localparam int GE_CACHE = 7;
  localparam int GE_NEGO = 6;
  localparam int GE_JOIN = 5;
  localparam int GE_WRMISS = 3;
  localparam int CT_AUTO_EN = 0;
  // Implemented bits per register; others read zero
  localparam logic [7:0] FIFO_EVT_MASK = 8'hFD;
  localparam logic [7:0] BULK_EVT_MASK = 8'hEC;
  localparam logic [7:0] DRV_EVT_MASK = 8'hF7;
  localparam logic [7:0] DBG_EVT_MASK = 8'hE8;
  localparam logic [7:0] DBG_W1C_MASK = 8'h60;
  localparam logic [7:0] CTRL_MASK = 8'h01;
  // ----------------------------------------
  // Wrapper lengths in bytes
  // ----------------------------------------
  localparam logic [7:0] CBW_BYTES = 8'h1F;
  localparam logic [7:0] CSW_BYTES = 8'h0D;
endpackage

// *** rtl/fbi_event_status.sv ***
// Event status registers for FIFO, bulk wrapper, drive port and debug events
// Contract
// - Writing one clears bit, except read-only debug bits; zero keeps it
// - Descriptor done when full length sent
// - Early status stage: descriptor done plus NAK
// - RAM fetch done when data registers loaded
// - Drive FIFO done: IN empty, OUT complete
// - Second DMA FIFO done likewise
// - First DMA FIFO done likewise
// - Selected FIFO full and empty flags
// - Command wrapper done at 31 clean bytes
// - Command wrapper length error if not 31
// - Command wrapper error on transaction error
// - Status wrapper done after 13 bytes
// - Status wrapper error on missing ACK
// - Drive register access done
// - Register access error during sequences
// - Sequential write done
// - Auto status read done
// - Drive DMA done
// - Drive irq edge when auto read off
// - Terminate seen during Ultra-DMA burst
// - Cache miss debug bit, read only
// - Auto negotiation error, write one clears
// - Buffer join conflict debug bit
// - Write miss debug bit, read only
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module fbi_event_status (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Descriptor reply and RAM fetch
  input wire logic desc_all_sent_i,
  input wire logic desc_early_status_i,
  input wire logic ram_fetch_loaded_i,
  output logic out_nak_flag_o,
  // Joined transfers: 0 first DMA, 1 second DMA, 2 drive
  input wire logic [2:0] join_xfer_end_i,
  input wire logic [2:0] join_dir_in_i,
  input wire logic [2:0] join_fifo_empty_i,
  // FIFO chosen by join_status_select
  input wire logic sel_fifo_full_i,
  input wire logic sel_fifo_empty_i,
  // Bulk-only wrappers
  input wire logic cbw_pkt_end_i,
  input wire logic [7:0] cbw_pkt_len_i,
  input wire logic cbw_xact_err_i,
  input wire logic csw_sent_i,
  input wire logic [7:0] csw_sent_len_i,
  input wire logic csw_no_ack_i,
  // Drive port engines
  input wire logic drv_reg_done_i,
  input wire logic drv_reg_req_i,
  input wire logic auto_read_busy_i,
  input wire logic seq_write_busy_i,
  input wire logic seq_write_done_i,
  input wire logic auto_read_done_i,
  input wire logic drv_dma_done_i,
  input wire logic udma_active_i,
  input wire logic drv_terminate_i,
  input wire logic drive_irq_input_i,
  output logic auto_status_read_enable_o,
  // Debug sources
  input wire logic cache_miss_i,
  input wire logic auto_nego_err_i,
  input wire logic join_conflict_i,
  input wire logic write_miss_i
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] fifo_evt_q;
  logic [7:0] fifo_evt_d;
  logic [7:0] bulk_evt_q;
  logic [7:0] bulk_evt_d;
  logic [7:0] drv_evt_q;
  logic [7:0] drv_evt_d;
  logic [7:0] dbg_evt_q;
  logic [7:0] dbg_evt_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [2:0] join_wait_q;
  logic [2:0] join_wait_d;
  logic [2:0] join_done;
  logic [2:0] irq_sync_q;
  logic [2:0] irq_sync_d;
  logic irq_level_q;
  logic irq_level_d;
  logic irq_rise;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic nak_q;
  logic nak_d;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic [7:0] fifo_set;
  logic [7:0] bulk_set;
  logic [7:0] drv_set;
  logic [7:0] dbg_set;
  logic [7:0] fifo_clr;
  logic [7:0] bulk_clr;
  logic [7:0] drv_clr;
  logic [7:0] dbg_clr;

  // Set wins: hardware event beats a same-cycle clear
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] mask);
    upd = ((cur & ~clr) | set) & mask;
  endfunction

  function automatic logic hit(input logic [9:0] adr, input logic [9:0] reg_adr);
    hit = (adr[9:2] == reg_adr[9:2]);
  endfunction

  // Wrapper length compare, shared by both wrapper checks
  function automatic logic len_is(input logic [7:0] len, input logic [7:0] want);
    len_is = (len == want);
  endfunction

  // ----------------------------------------
  // Bus write strobe
  // ----------------------------------------
  // Write lands on the edge where the master sees ack
  // Only byte lane 0 holds a register; upper lanes are ignored
  always_comb begin
    wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
    wr_byte = wb_dat_i[7:0];
  end

  // ----------------------------------------
  // Drive interrupt pin synchroniser
  // ----------------------------------------
  // Edge is judged on the last two stages only
  always_comb begin
    irq_sync_d = {irq_sync_q[1:0], drive_irq_input_i};
    irq_level_d = irq_level_q;
    if (irq_sync_q[2] == irq_sync_q[1]) begin
      irq_level_d = irq_sync_q[2];
    end
    irq_rise = (irq_sync_q[2] == irq_sync_q[1]) & irq_sync_q[2] & ~irq_level_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sync_q <= 3'h0;
      irq_level_q <= 1'b0;
    end else begin
      irq_sync_q <= irq_sync_d;
      irq_level_q <= irq_level_d;
    end
  end

  // ----------------------------------------
  // Joined transfer completion
  // ----------------------------------------
  // An IN endpoint is done only once its FIFO drains after the transfer
  // An IN FIFO that never drains keeps its channel waiting until reset or an OUT transfer end on that channel
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      join_wait_d[i] = join_wait_q[i];
      join_done[i] = 1'b0;
      if (join_xfer_end_i[i] && !join_dir_in_i[i]) begin
        join_done[i] = 1'b1;
        join_wait_d[i] = 1'b0;
      end else if (join_xfer_end_i[i] || join_wait_q[i]) begin
        if (join_fifo_empty_i[i]) begin
          join_done[i] = 1'b1;
          join_wait_d[i] = 1'b0;
        end else begin
          join_wait_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      join_wait_q <= 3'h0;
    end else begin
      join_wait_q <= join_wait_d;
    end
  end

  // ----------------------------------------
  // FIFO event sources
  // ----------------------------------------
  always_comb begin
    fifo_set = 8'h00;
    fifo_set[fbi_pkg::FE_DESC] = desc_all_sent_i | desc_early_status_i;
    fifo_set[fbi_pkg::FE_RAM] = ram_fetch_loaded_i;
    fifo_set[fbi_pkg::FE_DRV] = join_done[2];
    fifo_set[fbi_pkg::FE_DMA1] = join_done[1];
    fifo_set[fbi_pkg::FE_DMA0] = join_done[0];
    fifo_set[fbi_pkg::FE_FULL] = sel_fifo_full_i;
    fifo_set[fbi_pkg::FE_EMPTY] = sel_fifo_empty_i;
  end

  // ----------------------------------------
  // Bulk wrapper sources
  // ----------------------------------------
  always_comb begin
    bulk_set = 8'h00;
    bulk_set[fbi_pkg::BE_CBW_DONE] = cbw_pkt_end_i & ~cbw_xact_err_i & len_is(cbw_pkt_len_i, fbi_pkg::CBW_BYTES);
    bulk_set[fbi_pkg::BE_CBW_LEN] = cbw_pkt_end_i & ~len_is(cbw_pkt_len_i, fbi_pkg::CBW_BYTES);
    bulk_set[fbi_pkg::BE_COMMAND_WRAPPER_ERROR] = cbw_pkt_end_i & cbw_xact_err_i;
    bulk_set[fbi_pkg::BE_CSW_DONE] = csw_sent_i & len_is(csw_sent_len_i, fbi_pkg::CSW_BYTES);
    bulk_set[fbi_pkg::BE_STATUS_WRAPPER_ERROR] = csw_no_ack_i;
  end

  // ----------------------------------------
  // Drive port sources
  // ----------------------------------------
  always_comb begin
    drv_set = 8'h00;
    drv_set[fbi_pkg::DE_REG_DONE] = drv_reg_done_i;
    // A colliding access is only flagged here, not blocked
    // access collides with sequence
    drv_set[fbi_pkg::DE_REG_ERR] = drv_reg_req_i & (auto_read_busy_i | seq_write_busy_i);
    drv_set[fbi_pkg::DE_SEQ_DONE] = seq_write_done_i;
    drv_set[fbi_pkg::DE_AUTO_DONE] = auto_read_done_i;
    drv_set[fbi_pkg::DE_DMA_DONE] = drv_dma_done_i;
    drv_set[fbi_pkg::DE_IRQ] = irq_rise & ~ctrl_q[fbi_pkg::CT_AUTO_EN];
    drv_set[fbi_pkg::DE_TERM] = drv_terminate_i & udma_active_i;
  end

  // ----------------------------------------
  // Debug sources
  // ----------------------------------------
  always_comb begin
    dbg_set = 8'h00;
    dbg_set[fbi_pkg::GE_CACHE] = cache_miss_i;
    dbg_set[fbi_pkg::GE_NEGO] = auto_nego_err_i;
    dbg_set[fbi_pkg::GE_JOIN] = join_conflict_i;
    dbg_set[fbi_pkg::GE_WRMISS] = write_miss_i;
  end

  // ----------------------------------------
  // Write-one clears
  // ----------------------------------------
  always_comb begin
    fifo_clr = 8'h00;
    bulk_clr = 8'h00;
    drv_clr = 8'h00;
    dbg_clr = 8'h00;
    if (wr_stb && hit(wb_adr_i, fbi_pkg::FIFO_EVT_ADR)) begin
      fifo_clr = wr_byte;
    end
    if (wr_stb && hit(wb_adr_i, fbi_pkg::BULK_EVT_ADR)) begin
      bulk_clr = wr_byte;
    end
    if (wr_stb && hit(wb_adr_i, fbi_pkg::DRV_EVT_ADR)) begin
      drv_clr = wr_byte;
    end
    if (wr_stb && hit(wb_adr_i, fbi_pkg::DBG_EVT_ADR)) begin
      dbg_clr = wr_byte & fbi_pkg::DBG_W1C_MASK;
    end
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_comb begin
    fifo_evt_d = upd(fifo_evt_q, fifo_set, fifo_clr, fbi_pkg::FIFO_EVT_MASK);
    bulk_evt_d = upd(bulk_evt_q, bulk_set, bulk_clr, fbi_pkg::BULK_EVT_MASK);
    drv_evt_d = upd(drv_evt_q, drv_set, drv_clr, fbi_pkg::DRV_EVT_MASK);
    dbg_evt_d = upd(dbg_evt_q, dbg_set, dbg_clr, fbi_pkg::DBG_EVT_MASK);
    ctrl_d = ctrl_q;
    if (wr_stb && hit(wb_adr_i, fbi_pkg::CTRL_ADR)) begin
      ctrl_d = wr_byte & fbi_pkg::CTRL_MASK;
    end
    // NAK flag raised with early status stage
    nak_d = desc_early_status_i & ~desc_all_sent_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_evt_q <= fbi_pkg::EVT_RST;
      bulk_evt_q <= fbi_pkg::EVT_RST;
      drv_evt_q <= fbi_pkg::EVT_RST;
      dbg_evt_q <= fbi_pkg::EVT_RST;
      ctrl_q <= fbi_pkg::CTRL_RST;
      nak_q <= 1'b0;
    end else begin
      fifo_evt_q <= fifo_evt_d;
      bulk_evt_q <= bulk_evt_d;
      drv_evt_q <= drv_evt_d;
      dbg_evt_q <= dbg_evt_d;
      ctrl_q <= ctrl_d;
      nak_q <= nak_d;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // One wait state; unmapped addresses still ack with zero data
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = 32'h0000_0000;
    if (ack_d && !wb_we_i) begin
      if (hit(wb_adr_i, fbi_pkg::FIFO_EVT_ADR)) begin
        rdat_d[7:0] = fifo_evt_q;
      end else if (hit(wb_adr_i, fbi_pkg::BULK_EVT_ADR)) begin
        rdat_d[7:0] = bulk_evt_q;
      end else if (hit(wb_adr_i, fbi_pkg::DRV_EVT_ADR)) begin
        rdat_d[7:0] = drv_evt_q;
      end else if (hit(wb_adr_i, fbi_pkg::DBG_EVT_ADR)) begin
        rdat_d[7:0] = dbg_evt_q;
      end else if (hit(wb_adr_i, fbi_pkg::CTRL_ADR)) begin
        rdat_d[7:0] = ctrl_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    wb_ack_o = ack_q;
    wb_dat_o = rdat_q;
    out_nak_flag_o = nak_q;
    auto_status_read_enable_o = ctrl_q[fbi_pkg::CT_AUTO_EN];
  end

endmodule
`default_nettype wire

// *** dv/fbi_event_status_sva.sv ***
// Bus and side-output checker for the event status block
`timescale 1ns/1ns
`default_nettype none
module fbi_event_status_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic desc_all_sent_i,
  input wire logic desc_early_status_i,
  input wire logic out_nak_flag_o,
  input wire logic auto_status_read_enable_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd;
  logic req;
  logic early;
  logic dat0;
  logic ctl_wr;
  logic [7:0] ix;
  assign ix = wb_adr_i[9:2];
  assign rd = wb_ack_o && !wb_we_i;
  assign req = wb_cyc_i && wb_stb_i;
  assign early = desc_early_status_i && !desc_all_sent_i;
  assign dat0 = wb_dat_i[0];
  assign ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && ix == fbi_pkg::CTRL_IDX;
  chk_ack_one_wait: assert property ($rose(req) |=> wb_ack_o)
    else $error("ack late");
  chk_ack_one_beat: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  chk_fifo_rsvd_zero: assert property (rd && ix == fbi_pkg::FIFO_EVT_IDX |-> wb_dat_o[31:0] == {24'h000000, wb_dat_o[7:0] & 8'hFD})
    else $error("fifo reserved bit set");
  chk_bulk_rsvd_zero: assert property (rd && ix == fbi_pkg::BULK_EVT_IDX |-> wb_dat_o[31:0] == {24'h000000, wb_dat_o[7:0] & 8'hEC})
    else $error("bulk reserved bit set");
  chk_drv_rsvd_zero: assert property (rd && ix == fbi_pkg::DRV_EVT_IDX |-> wb_dat_o[31:0] == {24'h000000, wb_dat_o[7:0] & 8'hF7})
    else $error("drive reserved bit set");
  chk_dbg_rsvd_zero: assert property (rd && ix == fbi_pkg::DBG_EVT_IDX |-> wb_dat_o[31:0] == {24'h000000, wb_dat_o[7:0] & 8'hE8})
    else $error("debug reserved bit set");
  chk_nak_after_early: assert property (early |=> out_nak_flag_o)
    else $error("no nak after early status");
  chk_nak_has_cause: assert property (out_nak_flag_o |-> $past(early))
    else $error("nak without cause");
  chk_ctrl_takes_bit: assert property (ctl_wr |=> auto_status_read_enable_o == $past(dat0))
    else $error("control bit not written");
  cover property (rd && wb_dat_o != 32'h00000000);
  cover property (out_nak_flag_o);
  cover property (ctl_wr && dat0);
endmodule
bind fbi_event_status fbi_event_status_chk u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .desc_all_sent_i, .desc_early_status_i, .out_nak_flag_o, .auto_status_read_enable_o
);
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the event status block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  localparam logic [9:0] FA = fbi_pkg::FIFO_EVT_ADR;
  localparam logic [9:0] BA = fbi_pkg::BULK_EVT_ADR;
  localparam logic [9:0] DA = fbi_pkg::DRV_EVT_ADR;
  localparam logic [9:0] GA = fbi_pkg::DBG_EVT_ADR;
  localparam logic [9:0] CA = fbi_pkg::CTRL_ADR;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic nak;
  logic aen;
  logic [18:0] ev = 19'h00000;
  logic [2:0] dir_in = 3'h0;
  logic [2:0] fempty = 3'h0;
  logic full = 1'h0;
  logic empty = 1'h0;
  logic command_wrapper_error = 1'h0;
  logic [7:0] cbw_len = 8'h00;
  logic [7:0] csw_len = 8'h00;
  logic abusy = 1'h0;
  logic sbusy = 1'h0;
  logic udma = 1'h0;
  logic irq = 1'h0;
  logic [7:0] q;
  int err_total = 0;
  int compares = 0;
  always #5 clk_i = ~clk_i;
  fbi_event_status u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .desc_all_sent_i(ev[0]), .desc_early_status_i(ev[1]), .ram_fetch_loaded_i(ev[2]), .out_nak_flag_o(nak),
    .join_xfer_end_i(ev[18:16]), .join_dir_in_i(dir_in), .join_fifo_empty_i(fempty),
    .sel_fifo_full_i(full), .sel_fifo_empty_i(empty), .cbw_pkt_end_i(ev[3]), .cbw_pkt_len_i(cbw_len),
    .cbw_xact_err_i(command_wrapper_error), .csw_sent_i(ev[4]), .csw_sent_len_i(csw_len), .csw_no_ack_i(ev[5]),
    .drv_reg_done_i(ev[6]), .drv_reg_req_i(ev[7]), .auto_read_busy_i(abusy), .seq_write_busy_i(sbusy),
    .seq_write_done_i(ev[8]), .auto_read_done_i(ev[9]), .drv_dma_done_i(ev[10]), .udma_active_i(udma),
    .drv_terminate_i(ev[11]), .drive_irq_input_i(irq), .auto_status_read_enable_o(aen),
    .cache_miss_i(ev[12]), .auto_nego_err_i(ev[13]), .join_conflict_i(ev[14]), .write_miss_i(ev[15])
  );
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Holds the request until the edge that samples ack, then releases
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (ack !== 1'h1) begin
      err_total++;
      $display("[FAIL] %0t bus timeout", $time);
      summarize();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'h1;
    @(posedge clk_i);
    ev[i] <= 1'h0;
  endtask
  task automatic t_simple();
    int id[7] = '{0, 1, 2, 6, 8, 9, 10};
    logic [7:0] e[7] = '{8'h80, 8'h80, 8'h40, 8'h80, 8'h20, 8'h10, 8'h04};
    logic [9:0] a;
    foreach (id[i]) begin
      a = (id[i] < 6) ? FA : DA;
      pulse(id[i]);
      @(posedge clk_i);
      `CHK(nak, (id[i] == 1))
      rd(a, e[i]);
      bus(1'h1, a, 8'h00);
      rd(a, e[i]);
      bus(1'h1, a, 8'hFF);
      rd(a, 8'h00);
    end
    $display("simple events done");
  endtask
  task automatic t_fifo();
    int b[3] = '{fbi_pkg::FE_DMA0, fbi_pkg::FE_DMA1, fbi_pkg::FE_DRV};
    for (int k = 0; k < 3; k++) begin
      pulse(16 + k);
      rd(FA, 8'h01 << b[k]);
      bus(1'h1, FA, 8'hFF);
      dir_in[k] <= 1'h1;
      pulse(16 + k);
      rd(FA, 8'h00);
      fempty[k] <= 1'h1;
      @(posedge clk_i);
      fempty[k] <= 1'h0;
      dir_in[k] <= 1'h0;
      rd(FA, 8'h01 << b[k]);
      bus(1'h1, FA, 8'hFF);
    end
    full <= 1'h1;
    @(posedge clk_i);
    full <= 1'h0;
    rd(FA, 8'h08);
    empty <= 1'h1;
    bus(1'h1, FA, 8'h04);
    rd(FA, 8'h0C);
    empty <= 1'h0;
    bus(1'h1, FA, 8'hFF);
    rd(FA, 8'h00);
    $display("fifo events done");
  endtask
  task automatic t_bulk();
    logic [7:0] ln[4] = '{8'h1F, 8'h1E, 8'h1F, 8'h20};
    logic er[4] = '{1'h0, 1'h0, 1'h1, 1'h1};
    logic [7:0] e[4] = '{8'h80, 8'h40, 8'h20, 8'h60};
    foreach (ln[i]) begin
      cbw_len <= ln[i];
      command_wrapper_error <= er[i];
      pulse(3);
      rd(BA, e[i]);
      bus(1'h1, BA, 8'hFF);
    end
    csw_len <= 8'h0D;
    pulse(4);
    rd(BA, 8'h08);
    bus(1'h1, BA, 8'hFF);
    csw_len <= 8'h0C;
    pulse(4);
    pulse(5);
    rd(BA, 8'h04);
    $display("bulk events done");
  endtask
  task automatic t_drive();
    abusy <= 1'h1;
    pulse(7);
    abusy <= 1'h0;
    rd(DA, 8'h40);
    bus(1'h1, DA, 8'hFF);
    sbusy <= 1'h1;
    pulse(7);
    sbusy <= 1'h0;
    rd(DA, 8'h40);
    bus(1'h1, DA, 8'hFF);
    pulse(7);
    pulse(11);
    rd(DA, 8'h00);
    udma <= 1'h1;
    pulse(11);
    udma <= 1'h0;
    rd(DA, 8'h01);
    irq <= 1'h1;
    repeat (8) @(posedge clk_i);
    rd(DA, 8'h03);
    irq <= 1'h0;
    bus(1'h1, CA, 8'h01);
    bus(1'h1, DA, 8'hFF);
    `CHK(aen, 1'h1)
    irq <= 1'h1;
    repeat (8) @(posedge clk_i);
    rd(DA, 8'h00);
    irq <= 1'h0;
    sel <= 4'h0;
    bus(1'h1, CA, 8'h00);
    sel <= 4'hF;
    rd(CA, 8'h01);
    bus(1'h1, CA, 8'h00);
    $display("drive events done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 4; i++) rd(FA + 10'(4 * i), 8'h00);
    rd(CA, 8'h00);
    rd(10'h3FC, 8'h00);
    t_simple();
    t_fifo();
    t_bulk();
    t_drive();
    for (int i = 12; i < 16; i++) pulse(i);
    rd(GA, 8'hE8);
    bus(1'h1, GA, 8'hFF);
    rd(GA, 8'h88);
    // Read-only debug bits only leave through reset
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(GA, 8'h00);
    $display("debug events done");
    summarize();
  end
endmodule
`default_nettype wire
